// >>> dch_arb_pkg.sv
// Shared constants for the D-channel access arbiter and its local controller end
package dch_arb_pkg;

  // D-channel bit slot timing (16 kbit/s) at the 200 MHz system clock
  localparam int BIT_TIME_NS = 62500;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;

  // Stop/go encoding and its place in the last octet of channel 2
  localparam logic SG_STOP = 1'b1;
  localparam logic SG_GO = 1'b0;
  localparam int SG_BIT_POS = 5;

  // Consecutive-ones thresholds at the normal level; the lowered level adds one
  localparam logic [3:0] THR_CLASS_LOW = 4'h8;
  localparam logic [3:0] THR_CLASS_HIGH = 4'ha;
  localparam logic [3:0] THR_LOWER_STEP = 4'h1;
  localparam logic [3:0] ONES_MAX = 4'hf;

  // D-channel interface mode: collision detection / stop-go evaluation is 0x1 or 0x3 (bit 1 is masked off)
  localparam logic [2:0] DIM_ENABLE_MASK = 3'h5;
  localparam logic [2:0] DIM_ENABLE_VAL = 3'h1;

  // Transceiver mode select: both upper bits set picks intelligent NT
  localparam logic [1:0] MODE_INT_NT_HI = 2'h3;
  localparam logic [2:0] MODE_LT_T = 3'h1;

  // Bus-accessed flag: zero means a local controller holds the D channel
  localparam logic BAC_TAKEN = 1'b0;
  localparam logic BAC_FREE = 1'b1;

  // Controller register map (word offsets in bytes)
  localparam logic [3:0] REG_ACT_CTRL = 4'h0;
  localparam logic [3:0] REG_TX_DATA = 4'h4;
  localparam logic [3:0] REG_TX_CMD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // Field positions
  localparam int ACT_CLASS_HIGH_POS = 0;
  localparam int ACT_ENABLE_POS = 1;
  localparam int TX_START_POS = 0;
  localparam int TX_LEN_LSB = 8;
  localparam int TX_LEN_W = 5;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_DONE_POS = 1;
  localparam int ST_ABORT_POS = 2;
  localparam int ST_STOPGO_POS = 3;
  localparam int ST_ACTIND_POS = 4;

  // Reset values
  localparam logic [31:0] ACT_CTRL_RST = 32'h0;
  localparam logic [15:0] TX_DATA_RST = 16'hffff;

endpackage : dch_arb_pkg

// >>> dch_link_if.sv
// Local serial-bus link between the arbiter and a layer-2 controller
`timescale 1ns/100ps
`default_nettype none
interface dch_link_if;
  logic dbit_stb;
  logic stop_go;
  logic activate_indication;
  logic up_dbit;
  logic bus_accessed_flag;
  logic activate_request_class_low;
  logic activate_request_class_high;

  modport device (
    output dbit_stb,
    output stop_go,
    output activate_indication,
    input up_dbit,
    input bus_accessed_flag,
    input activate_request_class_low,
    input activate_request_class_high
  );

  modport ctrl (
    input dbit_stb,
    input stop_go,
    input activate_indication,
    output up_dbit,
    output bus_accessed_flag,
    output activate_request_class_low,
    output activate_request_class_high
  );
endinterface : dch_link_if
`default_nettype wire

// >>> dchannel_priority_access_arbiter.sv
// D-channel priority and collision arbiter of the S/T transceiver (device end)
// Behaviour
// - Present stop/go to local layer-2 devices.
// - Stop/go one stops, zero lets go.
// - Signalling uses class 1, else class 2.
// - Send continuous ones when not transmitting.
// - Channel idle only after seven-plus ones.
// - Thresholds 8/10 normal, 9/11 lowered.
// - Count echo ones; zero restarts; start at threshold.
// - Lower level after success; restore later.
// - On collision stop, monitor, send ones.
// - Compare echo with sent D when enabled.
// - Activation command selects class 8 or 10.
// - Controller answers indication with class request.
// - Trunk non-terminal frames: stop/go pin only.
// - Intelligent NT needs 12-slot frame, arbitration.
// - Stop/go for locals, inverted echo for terminals.
// - Count local ones; grant on request, invert echo.
// - Local threshold chosen by priority select.
// - Block bit zero halts all sources.
// - Upper mode bits select intelligent NT.
// - Software enables stop/go evaluation mode field.
// - Threshold 8/10 after abort, 9/11 after success.
// - Hold stop after local send until threshold.
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module dchannel_priority_access_arbiter #(
  parameter int BIT_DIV = dch_arb_pkg::BIT_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  dch_link_if.device LINK,
  input wire logic [2:0] TRANSCEIVER_MODE_SELECT,
  input wire logic [2:0] DCHAN_INTERFACE_MODE,
  input wire logic LOCAL_DCHAN_PRIORITY_SEL,
  input wire logic TE_FRAME_FORMAT,
  input wire logic ARB_BUS_ENABLE,
  input wire logic LINE_ACTIVATED,
  input wire logic EXCH_BLOCK,
  input wire logic S_ECHO_IN,
  input wire logic S_D_IN,
  output logic S_D_OUT,
  output logic S_ECHO_OUT,
  output logic EXCH_D_OUT,
  output logic STOP_GO_OUTPUT_PIN,
  output logic COLLISION,
  output logic PRIO_LOWERED,
  output logic CLASS_HIGH
);

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_GO = 3'b010,
    ST_TX = 3'b100
  } arb_state_t;

  arb_state_t state;
  arb_state_t next_state;
  logic [$clog2(BIT_DIV)-1:0] div_cnt;
  logic stb;
  logic [3:0] ones;
  logic lowered;
  logic class_high;
  logic stop_go;
  logic int_nt;
  logic trunk_no_frame;
  logic coll_en;
  logic count_bit;
  logic prio_high;
  logic [3:0] thr;
  logic collide;
  logic tx_end_ok;
  logic tx_abort;
  logic sent_d;

  function automatic logic [3:0] ones_threshold(input logic high, input logic low_level);
    logic [3:0] base;
    base = high ? dch_arb_pkg::THR_CLASS_HIGH : dch_arb_pkg::THR_CLASS_LOW;
    ones_threshold = base + (low_level ? dch_arb_pkg::THR_LOWER_STEP : 4'h0);
  endfunction : ones_threshold

  // Five bits wide so that a saturated run still counts as reached instead of wrapping to zero
  function automatic logic ones_reached(input logic [3:0] run, input logic [3:0] limit);
    ones_reached = ({1'b0, run} + 5'h01) >= {1'b0, limit};
  endfunction : ones_reached

  // Bit slot strobe; the arbiter is the timing source of the local bus
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt <= '0;
    end else if (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign stb = (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1));

  // Intelligent NT needs both upper mode bits, the 12-slot frame and the arbitration bus
  assign int_nt = (TRANSCEIVER_MODE_SELECT[2:1] == dch_arb_pkg::MODE_INT_NT_HI) &&
                  TE_FRAME_FORMAT && ARB_BUS_ENABLE;
  assign trunk_no_frame = (TRANSCEIVER_MODE_SELECT == dch_arb_pkg::MODE_LT_T) && !TE_FRAME_FORMAT;
  assign coll_en = (DCHAN_INTERFACE_MODE & dch_arb_pkg::DIM_ENABLE_MASK) ==
                   dch_arb_pkg::DIM_ENABLE_VAL;

  // In intelligent NT the local ones are counted; otherwise the S-bus echo
  assign count_bit = int_nt ? LINK.up_dbit : S_ECHO_IN;
  assign prio_high = int_nt ? LOCAL_DCHAN_PRIORITY_SEL : class_high;
  assign thr = ones_threshold(prio_high, lowered);

  // Collision: the echo differs from the D bit that was put on the line
  assign collide = !int_nt && coll_en && (state == ST_TX) && (S_ECHO_IN != sent_d);
  assign tx_end_ok = (state == ST_TX) && (LINK.bus_accessed_flag == dch_arb_pkg::BAC_FREE);
  assign tx_abort = (state == ST_TX) && (collide || (int_nt && !EXCH_BLOCK));

  // Activation class: each request latches its class, the controller may switch at will
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      class_high <= 1'b0;
    end else if (LINK.activate_request_class_high) begin
      class_high <= 1'b1;
    end else if (LINK.activate_request_class_low) begin
      class_high <= 1'b0;
    end
  end

  // Consecutive-ones counter, saturating well above the largest threshold
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ones <= '0;
    end else if (stb) begin
      if (!count_bit || state == ST_TX) begin
        ones <= '0;
      end else if (ones != dch_arb_pkg::ONES_MAX) begin
        ones <= ones + 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT: begin
        // Only a run of at least eight ones can be idle channel, never flag data
        if (count_bit && ones_reached(ones, thr) && EXCH_BLOCK) begin
          next_state = ST_GO;
        end
      end
      ST_GO: begin
        if (!EXCH_BLOCK) begin
          next_state = ST_WAIT;
        end else if (LINK.bus_accessed_flag == dch_arb_pkg::BAC_TAKEN) begin
          next_state = ST_TX;
        end else if (!count_bit) begin
          next_state = ST_WAIT;
        end
      end
      ST_TX: begin
        if (tx_abort || tx_end_ok) begin
          next_state = ST_WAIT;
        end
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_WAIT;
    end else if (stb) begin
      state <= next_state;
    end
  end

  // Priority level: lowered after success, normal after abort or a full idle run
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      lowered <= 1'b0;
    end else if (stb) begin
      if (tx_end_ok && !tx_abort) begin
        lowered <= 1'b1;
      end else if (tx_abort) begin
        lowered <= 1'b0;
      end else if (state != ST_TX && lowered && count_bit && ones_reached(ones, thr)) begin
        lowered <= 1'b0;
      end
    end
  end

  // Stop/go: go only while the channel is free or held by the local sender
  always_comb begin
    stop_go = (state == ST_WAIT) ? dch_arb_pkg::SG_STOP : dch_arb_pkg::SG_GO;
    if (int_nt && !EXCH_BLOCK) begin
      stop_go = dch_arb_pkg::SG_STOP;
    end
  end

  // Line drivers, updated once per bit slot
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sent_d <= 1'b1;
      S_D_OUT <= 1'b1;
      S_ECHO_OUT <= 1'b1;
      EXCH_D_OUT <= 1'b1;
    end else if (stb) begin
      if (!int_nt && next_state == ST_TX && !collide) begin
        sent_d <= LINK.up_dbit;
        S_D_OUT <= LINK.up_dbit;
      end else begin
        // Idle or after a collision the terminal side drives ones
        sent_d <= 1'b1;
        S_D_OUT <= 1'b1;
      end
      if (int_nt && (next_state == ST_TX || !EXCH_BLOCK)) begin
        S_ECHO_OUT <= !S_D_IN;
        EXCH_D_OUT <= (next_state == ST_TX) ? LINK.up_dbit : 1'b1;
      end else begin
        S_ECHO_OUT <= S_D_IN;
        EXCH_D_OUT <= S_D_IN;
      end
    end
  end

  // Collision report, one cycle per detected clash
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      COLLISION <= 1'b0;
    end else begin
      COLLISION <= stb && collide;
    end
  end

  // Serial-frame copy of stop/go; absent (idle ones) for trunk mode without terminal frames
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      LINK.stop_go <= dch_arb_pkg::SG_STOP;
      STOP_GO_OUTPUT_PIN <= dch_arb_pkg::SG_STOP;
      LINK.activate_indication <= 1'b0;
    end else begin
      LINK.stop_go <= trunk_no_frame ? 1'b1 : stop_go;
      STOP_GO_OUTPUT_PIN <= stop_go;
      LINK.activate_indication <= LINE_ACTIVATED;
    end
  end

  // The strobe is a handshake-type timing output and leaves combinationally
  assign LINK.dbit_stb = stb;
  assign PRIO_LOWERED = lowered;
  assign CLASS_HIGH = class_high;

endmodule : dchannel_priority_access_arbiter
`default_nettype wire

// >>> dch_local_controller.sv
// Local layer-2 D-channel controller end with a classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module dch_local_controller (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  dch_link_if.ctrl LINK,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O
);

  logic [31:0] act_ctrl;
  logic [15:0] tx_data;
  logic [15:0] shift;
  logic [4:0] bits_left;
  logic busy;
  logic sending;
  logic done;
  logic aborted;
  logic wr;
  logic start;
  logic fin_ok;
  logic fin_abort;

  // Writes land on the edge at which the master samples ack high, and only there
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
  assign start = wr && WB_ADR_I == dch_arb_pkg::REG_TX_CMD && WB_DAT_I[dch_arb_pkg::TX_START_POS] && !busy;
  assign fin_ok = LINK.dbit_stb && sending && bits_left == 5'h0;
  assign fin_abort = LINK.dbit_stb && sending && LINK.stop_go == dch_arb_pkg::SG_STOP;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      act_ctrl <= dch_arb_pkg::ACT_CTRL_RST;
      tx_data <= dch_arb_pkg::TX_DATA_RST;
    end else if (wr && WB_ADR_I == dch_arb_pkg::REG_ACT_CTRL) begin
      act_ctrl <= {30'h0, WB_DAT_I[1:0]};
    end else if (wr && WB_ADR_I == dch_arb_pkg::REG_TX_DATA && WB_SEL_I[1]) begin
      tx_data <= WB_DAT_I[15:0];
    end
  end

  always_comb begin
    WB_DAT_O = 32'h0;
    case (WB_ADR_I)
      dch_arb_pkg::REG_ACT_CTRL: WB_DAT_O = act_ctrl;
      dch_arb_pkg::REG_TX_DATA: WB_DAT_O = {16'h0, tx_data};
      dch_arb_pkg::REG_STATUS: WB_DAT_O = {27'h0, LINK.activate_indication, LINK.stop_go, aborted, done, busy};
      default: WB_DAT_O = 32'h0;
    endcase
  end

  // Sticky results; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      done <= 1'b0;
      aborted <= 1'b0;
    end else begin
      done <= (fin_ok && !fin_abort) ||
              (done && !(wr && WB_ADR_I == dch_arb_pkg::REG_STATUS && WB_DAT_I[dch_arb_pkg::ST_DONE_POS]));
      aborted <= fin_abort ||
                 (aborted && !(wr && WB_ADR_I == dch_arb_pkg::REG_STATUS && WB_DAT_I[dch_arb_pkg::ST_ABORT_POS]));
    end
  end

  // Wait for go, take the bus, shift bits while go holds, then release
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      busy <= 1'b0;
      sending <= 1'b0;
      shift <= '1;
      bits_left <= '0;
      LINK.up_dbit <= 1'b1;
      LINK.bus_accessed_flag <= dch_arb_pkg::BAC_FREE;
    end else if (start) begin
      busy <= 1'b1;
      shift <= tx_data;
      bits_left <= WB_DAT_I[dch_arb_pkg::TX_LEN_LSB +: dch_arb_pkg::TX_LEN_W];
    end else if (fin_ok || fin_abort) begin
      busy <= 1'b0;
      sending <= 1'b0;
      LINK.up_dbit <= 1'b1;
      LINK.bus_accessed_flag <= dch_arb_pkg::BAC_FREE;
    end else if (LINK.dbit_stb && busy && !sending && LINK.stop_go == dch_arb_pkg::SG_GO) begin
      sending <= 1'b1;
      LINK.bus_accessed_flag <= dch_arb_pkg::BAC_TAKEN;
    end else if (LINK.dbit_stb && sending && bits_left != 5'h0) begin
      LINK.up_dbit <= shift[15];
      shift <= {shift[14:0], 1'b1};
      bits_left <= bits_left - 1'b1;
    end
  end

  // Answer the activation indication with the request for the chosen class
  assign LINK.activate_request_class_high = act_ctrl[dch_arb_pkg::ACT_ENABLE_POS] &&
                                            LINK.activate_indication && act_ctrl[dch_arb_pkg::ACT_CLASS_HIGH_POS];
  assign LINK.activate_request_class_low = act_ctrl[dch_arb_pkg::ACT_ENABLE_POS] &&
                                           LINK.activate_indication && !act_ctrl[dch_arb_pkg::ACT_CLASS_HIGH_POS];

endmodule : dch_local_controller
`default_nettype wire

// >>> dch_arb_properties.sv
// Concurrent checks on the local serial-bus link between arbiter and controller
`timescale 1ns/100ps
`default_nettype none
module dch_arb_properties (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic dbit_stb,
  input wire logic stop_go,
  input wire logic activate_indication,
  input wire logic up_dbit,
  input wire logic bus_accessed_flag,
  input wire logic activate_request_class_low,
  input wire logic activate_request_class_high
);
  logic [3:0] ones;
  // Saturating run of local ones seen at strobes, so go can be tied to it
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ones <= 4'h0;
    end else if (dbit_stb) begin
      ones <= !up_dbit ? 4'h0 : (ones == 4'hf) ? ones : ones + 4'h1;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_strobe_period: assert property ($rose(dbit_stb) |=> !dbit_stb [*7] ##1 dbit_stb)
    else $error("bit strobe spacing wrong");
  a_bac_on_strobe: assert property ($changed(bus_accessed_flag) |-> $past(dbit_stb))
    else $error("bus accessed flag moved between strobes");
  a_dbit_on_strobe: assert property ($changed(up_dbit) |-> $past(dbit_stb))
    else $error("local D bit moved between strobes");
  a_idle_sends_ones: assert property (bus_accessed_flag |-> up_dbit)
    else $error("idle local D bit not one");
  a_start_on_go: assert property ($fell(bus_accessed_flag) |-> $past(dbit_stb && stop_go == dch_arb_pkg::SG_GO))
    else $error("access taken without go");
  a_class_exclusive: assert property (!(activate_request_class_low && activate_request_class_high))
    else $error("both class requests high");
  a_stop_after_send: assert property ($rose(bus_accessed_flag) |-> ##[1:12] stop_go == dch_arb_pkg::SG_STOP)
    else $error("stop not raised after local send");
  a_go_after_ones: assert property ($fell(stop_go) |-> ones >= dch_arb_pkg::THR_CLASS_LOW)
    else $error("go given before enough ones");
  c_access: cover property ($fell(bus_accessed_flag));
  c_go: cover property ($fell(stop_go));
  c_class_high: cover property (activate_indication && activate_request_class_high);
endmodule : dch_arb_properties
`default_nettype wire

// >>> testbench.sv
// Self-checking bench joining the arbiter and the local controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_n, we, cyc, stb, ack, line_act, blk, te_frame, arb_en, prio, echo_in, sd_in, echo_en, flip;
  logic sd_out, echo_out, exch_d, sg_pin, coll, lowered, cls_hi;
  logic [2:0] mode, dim;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, dout;
  logic [15:0] lf;
  int fails, n_checks, nb, nc, nh, nl;
  logic exp_q[$];
  logic got_q[$];
  dch_link_if dch_link_if_inst ();
  dchannel_priority_access_arbiter #(.BIT_DIV(8)) dchannel_priority_access_arbiter_inst (.CLK_SYS(clk),
    .RSTN(rst_n), .LINK(dch_link_if_inst), .TRANSCEIVER_MODE_SELECT(mode), .DCHAN_INTERFACE_MODE(dim),
    .LOCAL_DCHAN_PRIORITY_SEL(prio), .TE_FRAME_FORMAT(te_frame), .ARB_BUS_ENABLE(arb_en),
    .LINE_ACTIVATED(line_act), .EXCH_BLOCK(blk), .S_ECHO_IN(echo_in), .S_D_IN(sd_in), .S_D_OUT(sd_out),
    .S_ECHO_OUT(echo_out), .EXCH_D_OUT(exch_d), .STOP_GO_OUTPUT_PIN(sg_pin), .COLLISION(coll),
    .PRIO_LOWERED(lowered), .CLASS_HIGH(cls_hi));
  dch_local_controller dch_local_controller_inst (.CLK_SYS(clk), .RSTN(rst_n), .LINK(dch_link_if_inst),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dout), .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_ACK_O(ack));
  dch_arb_properties dch_arb_properties_inst (.CLK_SYS(clk), .RSTN(rst_n),
    .dbit_stb(dch_link_if_inst.dbit_stb), .stop_go(dch_link_if_inst.stop_go),
    .activate_indication(dch_link_if_inst.activate_indication), .up_dbit(dch_link_if_inst.up_dbit),
    .bus_accessed_flag(dch_link_if_inst.bus_accessed_flag),
    .activate_request_class_low(dch_link_if_inst.activate_request_class_low),
    .activate_request_class_high(dch_link_if_inst.activate_request_class_high));
  // Echo path of the S bus: loops the sent D bit back, flipped to force a collision
  always @(posedge clk) begin
    echo_in <= echo_en ? (sd_out ^ flip) : 1'b0;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic int thr(input bit hi, input bit low);
    return (hi ? 10 : 8) + low;
  endfunction : thr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkn(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chkn
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int t;
    t = 0;
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) fails++;
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(a, 1'b0, 32'h0, 4'hf);
    chk(rdat & m, e);
  endtask : rd
  task automatic strobe();
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (dch_link_if_inst.dbit_stb !== 1'b1 && t < 100);
    if (dch_link_if_inst.dbit_stb !== 1'b1) fails++;
  endtask : strobe
  task automatic meas(output int n);
    n = 0;
    do begin
      strobe();
      n++;
    end while (dch_link_if_inst.stop_go !== 1'b0 && n < 40);
    if (dch_link_if_inst.stop_go !== 1'b0) fails++;
  endtask : meas
  // Kind 0 sends whole, 1 is blocked by the exchange, 2 meets a collision
  task automatic send(input logic [15:0] d, input int kind);
    int i;
    int j;
    exp_q.delete();
    got_q.delete();
    wb(dch_arb_pkg::REG_TX_DATA, 1'b1, {16'h0, d}, 4'hf);
    wb(dch_arb_pkg::REG_TX_CMD, 1'b1, 32'h1001, 4'hf);
    for (i = 15; i >= 0; i--) exp_q.push_back(d[i]);
    i = 0;
    do begin
      strobe();
      i++;
    end while (dch_link_if_inst.bus_accessed_flag !== 1'b0 && i < 40);
    for (i = 0; i < 16; i++) begin
      strobe();
      got_q.push_back(dch_link_if_inst.up_dbit);
      if (i == 8 && kind == 0 && mode == 3'h6) chk(echo_out, !sd_in);
      if (i == 8 && kind == 0) chk(mode == 3'h6 ? exch_d : sd_out, exp_q[7]);
      if (i == 4 && kind == 1) blk <= 1'b0;
      if (i == 10 && kind == 1) begin
        chk(dch_link_if_inst.stop_go, dch_arb_pkg::SG_STOP);
        chk(echo_out, !sd_in);
      end
      if (i == 4 && kind == 2) begin
        flip <= 1'b1;
        j = 0;
        while (coll !== 1'b1 && j < 30) begin
          @(posedge clk);
          j++;
        end
        chk(coll, 1'b1);
        flip <= 1'b0;
        strobe();
        strobe();
        chk(sd_out, 1'b1);
        chk(lowered, 1'b0);
        i = 16;
      end
    end
    if (kind == 0) begin
      for (i = 0; i < 16; i++) chk(got_q[i], exp_q[i]);
    end
    strobe();
    repeat (3) @(posedge clk);
    if (kind == 0) chk(dch_link_if_inst.stop_go, dch_arb_pkg::SG_STOP);
    if (kind == 1) rd(dch_arb_pkg::REG_STATUS, 32'h4, 32'h4);
    blk <= 1'b1;
    wb(dch_arb_pkg::REG_STATUS, 1'b1, 32'h6, 4'hf);
  endtask : send
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #(5 * 60000);
    fails++;
    summarize();
  end
  initial begin
    rst_n <= 1'b0;
    {we, cyc, stb, line_act, flip, prio} <= 6'h0;
    {blk, te_frame, arb_en, sd_in, echo_en} <= 5'h1f;
    mode <= 3'h6;
    dim <= 3'h1;
    adr <= 4'h0;
    sel <= 4'h0;
    wdat <= 32'h0;
    lf = 16'h0052;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({sd_out, echo_out, exch_d, sg_pin}, 4'hf);
    rd(dch_arb_pkg::REG_ACT_CTRL, 32'hffffffff, dch_arb_pkg::ACT_CTRL_RST);
    wb(dch_arb_pkg::REG_TX_DATA, 1'b1, 32'h0, 4'h1);
    rd(dch_arb_pkg::REG_TX_DATA, 32'hffff, {16'h0, dch_arb_pkg::TX_DATA_RST});
    rd(4'h6, 32'hffffffff, 32'h0);
    meas(nb);
    for (int k = 0; k < 3; k++) begin
      lf = lfsr(lf);
      sd_in <= lf[0];
      prio <= k[0];
      send(lf & 16'hfffe, 0);
      meas(nc);
      if (k == 1) chkn(nc - nb, thr(1, 1) - thr(0, 1));
      nb = nc;
    end
    send(16'h0f0f, 1);
    mode <= 3'h0;
    line_act <= 1'b1;
    wb(dch_arb_pkg::REG_ACT_CTRL, 1'b1, 32'h3, 4'hf);
    repeat (4) strobe();
    chk(cls_hi, 1'b1);
    echo_en <= 1'b0;
    repeat (2) strobe();
    echo_en <= 1'b1;
    meas(nh);
    wb(dch_arb_pkg::REG_ACT_CTRL, 1'b1, 32'h2, 4'hf);
    repeat (4) strobe();
    chk(cls_hi, 1'b0);
    echo_en <= 1'b0;
    repeat (2) strobe();
    echo_en <= 1'b1;
    meas(nl);
    chkn(nh - nl, thr(1, 0) - thr(0, 0));
    lf = lfsr(lf);
    send(lf, 0);
    chk(lowered, 1'b1);
    echo_en <= 1'b0;
    repeat (2) strobe();
    echo_en <= 1'b1;
    meas(nh);
    chkn(nh - nl, thr(0, 1) - thr(0, 0));
    repeat (2) strobe();
    chk(lowered, 1'b0);
    send(16'h5555, 2);
    mode <= 3'h1;
    te_frame <= 1'b0;
    nb = 0;
    while (sg_pin !== 1'b0 && nb < 40) begin
      strobe();
      nb++;
    end
    chk(sg_pin, dch_arb_pkg::SG_GO);
    chk(dch_link_if_inst.stop_go, dch_arb_pkg::SG_STOP);
    summarize();
  end
endmodule : testbench
`default_nettype wire
